// *** verilog/outdrv_params.svh ***
// Field positions, offsets and counts of the output driver control block
`ifndef OUTDRV_PARAMS_SVH
`define OUTDRV_PARAMS_SVH

`define FRAME_BITS      16
`define ADDR_HI         15
`define ADDR_LO         13
`define RW_BIT          12
`define RANGE_HI        10
`define RANGE_LO        7
`define CLEAR_LEVEL_SELECT_BIT      6
`define OUTPUT_ENABLE_CONTROL_BIT       5
`define CLEAR_BIT       4
`define SENSE_RESISTOR_SELECT_BIT        3
`define RESET_BIT       2
`define RW_WRITE        1'h0
`define REG_CTRL        2'h0
`define REG_STATUS      2'h1
`define REG_COUNT       2'h2
`define REG_CONFIG      2'h3
`define CFG_BLOCK_BIT   0
`define INIT_CYCLES     2'h3
`define CURRENT_RANGE   3'h0
`define PIN_COUNT       15

`endif

// *** verilog/outdrv_pkg.sv ***
// Types and decode helpers shared by the output driver control files
package outdrv_pkg;

    typedef enum logic [1:0] {
        OUT_POWERUP = 2'b00,
        OUT_OFF     = 2'b01,
        OUT_ON      = 2'b10,
        OUT_CLEAR   = 2'b11
    } out_state_t;

    typedef struct packed {
        logic [3:0] range_select_bits;
        logic       clear_level_select;
        logic       output_enable_control;
        logic       clear_bit;
        logic       sense_resistor_select;
        logic       reset_bit;
    } ctrl_t;

    // Current ranges are the codes with the upper three range bits clear
    function automatic logic is_current_range(input logic [3:0] range);
        is_current_range = (range[3:1] == 3'h0);
    endfunction

endpackage

// *** verilog/serial_word_if.sv ***
// Carrier for received serial words between shifter and control core
`timescale 1ns/1ps
interface serial_word_if;
    logic [15:0] word;
    logic        word_valid;
    logic        frame_abort;

    modport src (output word, output word_valid, output frame_abort);
    modport snk (input word, input word_valid, input frame_abort);
endinterface

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_q <= '0;
            q_out   <= '0;
        end else begin
            stage_q <= d_in;
            q_out   <= stage_q;
        end
    end
endmodule

// *** verilog/serial_shifter.sv ***
// Input shift register: samples data on serial clock falls inside a frame
`timescale 1ns/1ps
`include "outdrv_params.svh"
module serial_shifter (
    input  wire logic   clk_in,
    input  wire logic   rst_n_in,
    input  wire logic   sclk_s_in,
    input  wire logic   sync_n_s_in,
    input  wire logic   sdin_s_in,
    serial_word_if.src  word_if
);
    logic [15:0] shift_q;
    logic [4:0]  count_q;
    logic        sclk_prev_q;
    logic        sync_prev_q;
    logic        sclk_fall;
    logic        frame_end;

    // Each link clock phase must span at least two clk_in cycles
    assign sclk_fall = sclk_prev_q & ~sclk_s_in;
    assign frame_end = ~sync_prev_q & sync_n_s_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_prev_q <= 1'h0;
            sync_prev_q <= 1'h1;
        end else begin
            sclk_prev_q <= sclk_s_in;
            sync_prev_q <= sync_n_s_in;
        end
    end

    // MSB first: each falling edge shifts one bit in at the bottom
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= 16'h0;
            count_q <= 5'h0;
        end else if (sync_n_s_in) begin
            count_q <= 5'h0;
        end else if (sclk_fall) begin
            shift_q <= {shift_q[14:0], sdin_s_in};
            if (count_q != 5'h1f) begin
                count_q <= count_q + 5'h1;
            end
        end
    end

    // Only a frame of exactly sixteen bits is handed on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_if.word        <= 16'h0;
            word_if.word_valid  <= 1'h0;
            word_if.frame_abort <= 1'h0;
        end else begin
            word_if.word_valid  <= 1'h0;
            word_if.frame_abort <= 1'h0;
            if (frame_end) begin
                if (count_q == 5'(`FRAME_BITS)) begin
                    word_if.word       <= shift_q;
                    word_if.word_valid <= 1'h1;
                end else if (count_q != 5'h0) begin
                    word_if.frame_abort <= 1'h1;
                end
            end
        end
    end
endmodule

// *** verilog/outdrv_control.sv ***
// Output driver control core: power-up, reset, enable, range and serial port
// Overview of operation
// - Software mode, clear high at power-up: voltage output driven at 0 V.
// - Software mode, clear low at power-up: voltage output tristated.
// - Current output always starts tristated at power-up in software mode.
// - Clear high during enabling write moves output to the clear level.
// - Hardware mode takes power-up state from range straps and enable pin.
// - Power-on reset loads every internal register with zero, except sync_prev_q, which loads one.
// - Software mode starts with output enable cleared, outputs disabled.
// - Software reset by low reset pin or a write with reset bit set.
// - A reset returns both outputs to their disabled power-on state.
// - Reset pin is level sensitive; held in reset while it is low.
// - Stored reset bit clears itself after the reset is carried out.
// - Hardware mode has no reset; board holds reset pin high.
// - Output enable cleared in software mode tristates both channels, except in the power-up state.
// - Hardware mode: enable pin controls output; disabled tristates both.
// - Mode strap tied low selects software mode with serial control.
// - Serial clock may run up to 50 MHz, host keeps below it.
// - Each write is a 16-bit word, most significant bit first.
// - Serial data is sampled on falling edges of the serial clock.
// - Three leading bits are a board address for up to eight devices.
// - A word is acted on only when its address matches the straps.
// - Word layout: address 15..13, write flag 12, range 10..7, flags 6..2.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "outdrv_params.svh"
module outdrv_control
    import outdrv_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        sclk_in,
    input  wire logic        sync_n_in,
    input  wire logic        sdin_in,
    input  wire logic        clear_in,
    input  wire logic        pin_reset_n_in,
    input  wire logic        hw_sw_mode_strap_in,
    input  wire logic [2:0]  address_strap_inputs_in,
    input  wire logic [3:0]  hw_range_strap_in,
    input  wire logic        hw_output_enable_in,
    input  wire logic        hw_clear_level_select_in,
    input  wire logic [1:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    output logic             vout_enable_out,
    output logic             vout_zero_out,
    output logic             iout_enable_out,
    output logic             clear_level_out,
    output logic      [3:0]  range_select_bits_out,
    output logic             clear_level_select_out,
    output logic             sense_resistor_select_out
);
    logic [`PIN_COUNT-1:0] pins_s;
    logic                  sclk_s;
    logic                  sync_n_s;
    logic                  sdin_s;
    logic                  clear_s;
    logic                  pin_reset_n_s;
    logic                  hw_sel_s;
    logic [2:0]            addr_strap_s;
    logic [3:0]            range_strap_s;
    logic                  oe_pin_s;
    logic                  clear_level_select_pin_s;

    logic [1:0]            init_cnt_q;
    logic                  init_done_q;
    logic                  hw_mode_q;
    logic                  clear_at_pu_q;
    ctrl_t                 ctrl_q;
    ctrl_t                 word_ctrl;
    out_state_t            state_q;
    out_state_t            state_d;
    logic                  serial_block_q;
    logic [7:0]            accept_cnt_q;
    logic [7:0]            discard_cnt_q;

    logic                  sw_reset;
    logic                  addr_match;
    logic                  word_accept;
    logic                  word_discard;
    logic                  enable_req;
    logic [3:0]            eff_range;
    logic                  eff_clear_level_select;
    logic                  eff_sense_resistor_select;

    serial_word_if word_if ();

    pin_sync #(
        .WIDTH (`PIN_COUNT)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({sclk_in, sync_n_in, sdin_in, clear_in, pin_reset_n_in,
                    hw_sw_mode_strap_in, address_strap_inputs_in,
                    hw_range_strap_in, hw_output_enable_in,
                    hw_clear_level_select_in}),
        .q_out    (pins_s)
    );

    assign {sclk_s, sync_n_s, sdin_s, clear_s, pin_reset_n_s, hw_sel_s,
            addr_strap_s, range_strap_s, oe_pin_s, clear_level_select_pin_s} = pins_s;

    serial_shifter u_shifter (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .sclk_s_in   (sclk_s),
        .sync_n_s_in (sync_n_s),
        .sdin_s_in   (sdin_s),
        .word_if     (word_if)
    );

    // Straps are caught once the synchronisers have filled after release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_cnt_q    <= 2'h0;
            init_done_q   <= 1'h0;
            hw_mode_q     <= 1'h0;
            clear_at_pu_q <= 1'h0;
        end else if (!init_done_q) begin
            if (init_cnt_q == `INIT_CYCLES) begin
                init_done_q   <= 1'h1;
                hw_mode_q     <= hw_sel_s;
                clear_at_pu_q <= clear_s;
            end else begin
                init_cnt_q <= init_cnt_q + 2'h1;
            end
        end
    end

    // Word decode into control fields
    always_comb begin
        word_ctrl.range_select_bits =
            word_if.word[`RANGE_HI:`RANGE_LO];
        word_ctrl.clear_level_select    = word_if.word[`CLEAR_LEVEL_SELECT_BIT];
        word_ctrl.output_enable_control = word_if.word[`OUTPUT_ENABLE_CONTROL_BIT];
        word_ctrl.clear_bit             = word_if.word[`CLEAR_BIT];
        word_ctrl.sense_resistor_select = word_if.word[`SENSE_RESISTOR_SELECT_BIT];
        word_ctrl.reset_bit             = word_if.word[`RESET_BIT];
    end

    // Board address must equal the strap pins
    assign addr_match = (word_if.word[`ADDR_HI:`ADDR_LO] ==
                         addr_strap_s);
    assign word_accept = word_if.word_valid & addr_match & init_done_q &
                         ~hw_mode_q & ~serial_block_q &
                         (word_if.word[`RW_BIT] == `RW_WRITE);
    assign word_discard = word_if.frame_abort |
                          (word_if.word_valid & ~word_accept);

    // Level-held pin or stored bit; hardware mode ignores both
    assign sw_reset = init_done_q & ~hw_mode_q &
                      (~pin_reset_n_s | ctrl_q.reset_bit);

    // Control register: zero at power-on and after any reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= '0;
        end else if (sw_reset) begin
            ctrl_q <= '0;
        end else if (word_accept) begin
            ctrl_q <= word_ctrl;
        end
    end

    // Effective settings from straps or from the control register
    always_comb begin
        if (hw_mode_q) begin
            enable_req = oe_pin_s;
            eff_range  = range_strap_s;
            eff_clear_level_select = clear_level_select_pin_s;
            eff_sense_resistor_select   = 1'h0;
        end else begin
            enable_req = ctrl_q.output_enable_control;
            eff_range  = ctrl_q.range_select_bits;
            eff_clear_level_select = ctrl_q.clear_level_select;
            eff_sense_resistor_select   = ctrl_q.sense_resistor_select;
        end
    end

    // Output condition: power-up, disabled, following or held at clear
    always_comb begin
        state_d = state_q;
        if (!init_done_q || sw_reset) begin
            state_d = OUT_POWERUP;
        end else if (!enable_req) begin
            if (state_q == OUT_POWERUP && !hw_mode_q) begin
                state_d = OUT_POWERUP;
            end else begin
                state_d = OUT_OFF;
            end
        end else if (clear_s) begin
            state_d = OUT_CLEAR;
        end else begin
            state_d = OUT_ON;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= OUT_POWERUP;
        end else begin
            state_q <= state_d;
        end
    end

    // Output stage controls, registered from the next condition
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vout_enable_out <= 1'h0;
            vout_zero_out   <= 1'h0;
            iout_enable_out <= 1'h0;
            clear_level_out <= 1'h0;
        end else begin
            unique case (state_d)
                OUT_POWERUP: begin
                    // Clear high at power-up drives 0 V, else tristate
                    vout_enable_out <= init_done_q & ~hw_mode_q &
                                       clear_at_pu_q;
                    vout_zero_out   <= init_done_q & ~hw_mode_q &
                                       clear_at_pu_q;
                    iout_enable_out <= 1'h0;
                    clear_level_out <= 1'h0;
                end
                OUT_OFF: begin
                    vout_enable_out <= 1'h0;
                    vout_zero_out   <= 1'h0;
                    iout_enable_out <= 1'h0;
                    clear_level_out <= 1'h0;
                end
                OUT_ON, OUT_CLEAR: begin
                    vout_enable_out <= ~is_current_range(eff_range);
                    vout_zero_out   <= 1'h0;
                    iout_enable_out <= is_current_range(eff_range);
                    clear_level_out <= (state_d == OUT_CLEAR);
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            range_select_bits_out     <= 4'h0;
            clear_level_select_out    <= 1'h0;
            sense_resistor_select_out <= 1'h0;
        end else begin
            range_select_bits_out     <= eff_range;
            clear_level_select_out    <= eff_clear_level_select;
            sense_resistor_select_out <= eff_sense_resistor_select;
        end
    end

    // Frame statistics, wrapping
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            accept_cnt_q  <= 8'h0;
            discard_cnt_q <= 8'h0;
        end else begin
            if (word_accept) begin
                accept_cnt_q <= accept_cnt_q + 8'h1;
            end
            if (word_discard) begin
                discard_cnt_q <= discard_cnt_q + 8'h1;
            end
        end
    end

    // Configuration register: blocks the serial port when set
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            serial_block_q <= 1'h0;
        end else if (reg_wr_in && reg_addr_in == `REG_CONFIG) begin
            serial_block_q <= reg_wdata_in[`CFG_BLOCK_BIT];
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `REG_CTRL:   reg_rdata_out <= {7'h0, ctrl_q};
                `REG_STATUS: reg_rdata_out <= {10'h0, clear_at_pu_q,
                                               clear_s, init_done_q,
                                               hw_mode_q, state_q};
                `REG_COUNT:  reg_rdata_out <= {discard_cnt_q,
                                               accept_cnt_q};
                `REG_CONFIG: reg_rdata_out <= {15'h0, serial_block_q};
            endcase
        end else begin
            reg_rdata_out <= 16'h0;
        end
    end
endmodule

// *** verification/outdrv_control_assertions.sv ***
// Port-level assertions for the output driver control core
`timescale 1ns/1ps
module outdrv_control_checker (
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       sync_n_in,
    input wire logic       clear_in,
    input wire logic       pin_reset_n_in,
    input wire logic       hw_sw_mode_strap_in,
    input wire logic [3:0] hw_range_strap_in,
    input wire logic       hw_output_enable_in,
    input wire logic       vout_enable_out,
    input wire logic       iout_enable_out,
    input wire logic [3:0] range_select_bits_out
);
    logic [3:0] up_q;

    // Edges since reset release, saturating
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_q <= 4'h0;
        end else if (up_q != 4'hf) begin
            up_q <= up_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_one_channel: assert property (
        !(vout_enable_out && iout_enable_out))
        else $error("both channels driven");
    a_iout_range: assert property (
        iout_enable_out |-> range_select_bits_out[3:1] == 3'h0)
        else $error("current channel on a voltage range");
    a_reset_quiet: assert property (
        up_q < 4'h3 |-> !vout_enable_out && !iout_enable_out
            && range_select_bits_out == 4'h0)
        else $error("outputs not clear after reset");
    a_pin_reset_hold: assert property (
        (!hw_sw_mode_strap_in && !pin_reset_n_in && !clear_in)[*5]
        |=> !iout_enable_out && range_select_bits_out == 4'h0)
        else $error("reset pin low but control kept");
    a_hw_range_follow: assert property (
        (hw_sw_mode_strap_in && up_q == 4'hf
            && $stable(hw_range_strap_in))[*6]
        |=> range_select_bits_out == hw_range_strap_in)
        else $error("range does not follow straps");
    a_hw_enable_pin: assert property (
        (hw_sw_mode_strap_in && !hw_output_enable_in && !clear_in)[*6]
        |=> !vout_enable_out && !iout_enable_out)
        else $error("disabled pin but channel driven");
    a_hw_no_reset: assert property (
        (hw_sw_mode_strap_in && up_q == 4'hf && hw_output_enable_in
            && !clear_in)[*6]
        |=> vout_enable_out || iout_enable_out)
        else $error("enabled pin but no channel driven");
    a_idle_stable: assert property (
        (sync_n_in && pin_reset_n_in && !hw_sw_mode_strap_in)[*8]
        |=> $stable(range_select_bits_out))
        else $error("range changed without a frame");
endmodule

bind outdrv_control outdrv_control_checker outdrv_control_checker_i (
    .clk_in, .rst_n_in, .sync_n_in, .clear_in, .pin_reset_n_in,
    .hw_sw_mode_strap_in, .hw_range_strap_in, .hw_output_enable_in,
    .vout_enable_out, .iout_enable_out, .range_select_bits_out);

// *** verification/host_serial_model.sv ***
// Host side of the serial write link; clock idles high between frames
`timescale 1ns/1ps
module host_serial_model (
    output logic sclk_out,
    output logic sync_n_out,
    output logic sdin_out
);
    initial begin
        sclk_out   = 1'b1;
        sync_n_out = 1'b1;
        sdin_out   = 1'b1;
    end

    // Half period of 400 ns, well under the top link rate
    task automatic send(input logic [15:0] w, input int nbits);
        logic [15:0] v;
        v = w & 16'hf7fc;
        #37;
        sync_n_out = 1'b0;
        #400;
        for (int i = 15; i > 15 - nbits; i--) begin
            sclk_out = 1'b1;
            sdin_out = v[i];
            #400;
            sclk_out = 1'b0;
            #400;
        end
        sclk_out = 1'b1;
        #400;
        sync_n_out = 1'b1;
        // Released data line shows no stale bit
        sdin_out = ~sdin_out;
        #800;
    endtask
endmodule

// *** verification/output_driver_control_serial_port_tb_top.sv ***
// Self-checking bench for the output driver control core
`timescale 1ns/1ps
module output_driver_control_serial_port_tb_top;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        sclk, sync_n, sdin;
    logic        clear_in = 1'b0;
    logic        pin_reset_n_in = 1'b1;
    logic        hw_mode = 1'b0;
    logic [2:0]  straps = 3'h0;
    logic [3:0]  hw_range = 4'h5;
    logic        hw_oe = 1'b0;
    logic        hw_clear_level_select = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [15:0] wdata = 16'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        ve, vz, ie, cl, csel, rsel;
    logic [3:0]  rng;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;

    always #50 clk_in = ~clk_in;

    outdrv_control outdrv_control_i (
        .clk_in, .rst_n_in, .sclk_in(sclk), .sync_n_in(sync_n),
        .sdin_in(sdin), .clear_in, .pin_reset_n_in,
        .hw_sw_mode_strap_in(hw_mode), .address_strap_inputs_in(straps),
        .hw_range_strap_in(hw_range), .hw_output_enable_in(hw_oe),
        .hw_clear_level_select_in(hw_clear_level_select), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .vout_enable_out(ve), .vout_zero_out(vz),
        .iout_enable_out(ie), .clear_level_out(cl),
        .range_select_bits_out(rng), .clear_level_select_out(csel),
        .sense_resistor_select_out(rsel));

    host_serial_model host_serial_model_i (
        .sclk_out(sclk), .sync_n_out(sync_n), .sdin_out(sdin));

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [15:0] exp,
                        input string msg);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 check(rdata, exp, msg);
    endtask

    // Expected channel flags: vout enable, vout zero, iout enable
    task automatic ochk(input logic [2:0] exp, input string msg);
        check({13'h0, ve, vz, ie}, {13'h0, exp}, msg);
    endtask

    // Word from address, range and flags {clear select, enable, reset}
    function automatic logic [15:0] fw(input logic [2:0] a,
                                       input logic [3:0] r,
                                       input logic [2:0] f);
        fw = {a, 2'b00, r, f[2], f[1], 2'b00, f[0], 2'b00};
    endfunction

    // Control register readback for a range, clear select and enable
    function automatic logic [15:0] cr(input logic [3:0] r,
                                       input logic s, input logic e);
        cr = {7'h0, r, s, e, 3'h0};
    endfunction

    task automatic send(input logic [15:0] w, input int n);
        host_serial_model_i.send(w, n);
        repeat (8) @(posedge clk_in);
    endtask

    task automatic do_reset(input logic m, input logic c);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        hw_mode  <= m;
        clear_in <= c;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        do_reset(1'b0, 1'b0);
        ochk(3'b000, "powerup tristate");
        rchk(2'h0, 16'h0000, "ctrl zero");
        rchk(2'h2, 16'h0000, "count zero");
        rchk(2'h1, 16'h0008, "status sw mode");
        // Each strap value: a neighbour address is dropped, its own taken
        for (int a = 0; a < 8; a++) begin
            straps <= 3'(a);
            send(fw(3'(a + 1), 4'h5, 3'b010), 16);
            send(fw(3'(a), 4'h5, 3'b010), 16);
            rchk(2'h2, {8'(a + 1), 8'(a + 1)}, "addr filter");
        end
        ochk(3'b100, "enabled voltage");
        send(fw(3'h7, 4'h1, 3'b010), 15);
        send(fw(3'h7, 4'h1, 3'b010) | 16'h1000, 16);
        rchk(2'h2, 16'h0a08, "bad frames");
        rchk(2'h0, cr(4'h5, 1'b0, 1'b1), "ctrl kept");
        send(fw(3'h7, 4'h1, 3'b110) | 16'h0008, 16);
        ochk(3'b001, "current on");
        check({15'h0, csel}, 16'h1, "clear select");
        check({15'h0, rsel}, 16'h1, "sense select");
        rchk(2'h0, cr(4'h1, 1'b1, 1'b1) | 16'h0002, "ctrl current");
        send(fw(3'h7, 4'h1, 3'b000), 16);
        ochk(3'b000, "disabled");
        send(fw(3'h7, 4'h5, 3'b011), 16);
        rchk(2'h0, 16'h0000, "reset bit self clear");
        ochk(3'b000, "reset bit off");
        send(fw(3'h7, 4'h5, 3'b010), 16);
        pin_reset_n_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        ochk(3'b000, "pin reset off");
        send(fw(3'h7, 4'h5, 3'b010), 16);
        rchk(2'h0, 16'h0000, "held in reset");
        pin_reset_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        ochk(3'b000, "stays off");
        clear_in <= 1'b1;
        send(fw(3'h7, 4'h5, 3'b010), 16);
        check({15'h0, cl}, 16'h1, "clear level");
        clear_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        check({15'h0, cl}, 16'h0, "clear released");
        ochk(3'b100, "normal");
        bus_wr(2'h3, 16'h0001);
        rchk(2'h3, 16'h0001, "config");
        send(fw(3'h7, 4'h5, 3'b000), 16);
        bus_wr(2'h0, 16'h0000);
        ochk(3'b100, "blocked frame");
        rchk(2'h0, cr(4'h5, 1'b0, 1'b1), "ctrl read only");
        do_reset(1'b0, 1'b1);
        ochk(3'b110, "powerup 0 V");
        hw_oe <= 1'b1;
        do_reset(1'b1, 1'b0);
        check({12'h0, rng}, 16'h0005, "hw range");
        ochk(3'b100, "hw enabled");
        pin_reset_n_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        ochk(3'b100, "hw no reset");
        pin_reset_n_in <= 1'b1;
        hw_oe <= 1'b0;
        repeat (10) @(posedge clk_in);
        ochk(3'b000, "hw disabled");
        end_of_test();
    end
endmodule
